// File: quad_dac_cfg_defines.svh
`ifndef QUAD_DAC_CFG_DEFINES_SVH
`define QUAD_DAC_CFG_DEFINES_SVH

`define QDC_ADDR_W      8
`define QDC_DATA_W      32
`define QDC_CHANNELS    4
`define QDC_GAIN_CAL_W  8
`define QDC_ZERO_CAL_W  9
`define QDC_MON_W       3

// Register byte addresses, and calibration page numbers matched against address bits 7:4
`define QDC_CMD_ADDR    8'h00
`define QDC_MON_ADDR    8'h04
`define QDC_STAT_ADDR   8'h08
`define QDC_GAIN_PAGE   4'h1
`define QDC_ZERO_PAGE   4'h2

// Command register fields
`define QDC_CMD_GAIN_LSB 0
`define QDC_CMD_SRST_BIT 4

// Reset values
`define QDC_GAIN_RST    4'hf
`define QDC_GCAL_RST    8'h00
`define QDC_ZCAL_RST    9'h000

// Calibration step sizes, in millionths of an LSB
`define QDC_GAIN_STEP_ULSB 62500
`define QDC_ZERO_STEP_ULSB 7800

`endif

// File: quad_dac_cfg_pkg.sv
`default_nettype none
package quad_dac_cfg_pkg;

    typedef enum logic [2:0] {
        MON_OFF  = 3'b000,
        MON_CH0  = 3'b001,
        MON_CH1  = 3'b010,
        MON_CH2  = 3'b011,
        MON_CH3  = 3'b100,
        MON_AUX  = 3'b101
    } mon_sel_t;

    typedef struct packed {
        logic             gain_x4;
        logic             unipolar;
        logic             twos_comp;
        logic signed [7:0] gain_cal;
        logic signed [8:0] zero_cal;
    } chan_cfg_t;

    typedef struct packed {
        logic       hiz;
        logic       aux;
        logic [3:0] chan;
    } mon_route_t;

endpackage
`default_nettype wire

// File: quad_dac_cfg.sv
// The register offsets and the address-and-strobe port are this design's own decisions.
`include "quad_dac_cfg_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module quad_dac_cfg
    import quad_dac_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_reset_n,
    // Register port
    input  wire logic [`QDC_ADDR_W-1:0] i_addr,
    input  wire logic [`QDC_DATA_W-1:0] i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [`QDC_DATA_W-1:0] o_rdata,
    // Polarity straps
    input  wire logic                   i_group_a_polarity_select,
    input  wire logic                   i_group_b_polarity_select,
    // Channel settings
    output chan_cfg_t                   o_chan_cfg [`QDC_CHANNELS],
    // Monitor routing
    output mon_route_t                  o_analog_monitor_output
);

    function automatic mon_route_t route_of(input logic [2:0] sel);
        mon_route_t r;
        r = '{hiz: 1'b1, aux: 1'b0, chan: 4'h0};
        case (sel)
            MON_CH0: r = '{hiz: 1'b0, aux: 1'b0, chan: 4'h1};
            MON_CH1: r = '{hiz: 1'b0, aux: 1'b0, chan: 4'h2};
            MON_CH2: r = '{hiz: 1'b0, aux: 1'b0, chan: 4'h4};
            MON_CH3: r = '{hiz: 1'b0, aux: 1'b0, chan: 4'h8};
            MON_AUX: r = '{hiz: 1'b0, aux: 1'b1, chan: 4'h0};
            default: r = '{hiz: 1'b1, aux: 1'b0, chan: 4'h0};
        endcase
        return r;
    endfunction

    function automatic logic [2:0] code_of(input mon_route_t r);
        logic [2:0] c;
        c = MON_OFF;
        if (r.aux) begin
            c = MON_AUX;
        end else begin
            case (r.chan)
                4'h1:    c = MON_CH0;
                4'h2:    c = MON_CH1;
                4'h4:    c = MON_CH2;
                4'h8:    c = MON_CH3;
                default: c = MON_OFF;
            endcase
        end
        return c;
    endfunction

    logic [3:0]                      gain_q;
    logic [1:0]                      pol_q;
    logic signed [7:0]               gcal_q [`QDC_CHANNELS];
    logic signed [8:0]               zcal_q [`QDC_CHANNELS];
    mon_route_t                      mon_q;
    logic [`QDC_DATA_W-1:0]          rdata_q;
    logic [`QDC_DATA_W-1:0]          rdata_d;

    wire        wr_cmd  = i_wr && (i_addr == `QDC_CMD_ADDR);
    wire        wr_mon  = i_wr && (i_addr == `QDC_MON_ADDR);
    wire        soft_rst = wr_cmd && i_wdata[`QDC_CMD_SRST_BIT];
    wire        gain_pg = (i_addr[7:4] == `QDC_GAIN_PAGE);
    wire        zero_pg = (i_addr[7:4] == `QDC_ZERO_PAGE);
    wire [1:0]  ch_idx  = i_addr[3:2];
    wire        aligned = (i_addr[1:0] == 2'b00);
    wire        wr_gcal = i_wr && gain_pg && aligned;
    wire        wr_zcal = i_wr && zero_pg && aligned;

    // Readback decode, calibration sign extended
    always_comb begin
        rdata_d = '0;
        if (i_addr == `QDC_CMD_ADDR) begin
            rdata_d = {28'h0, gain_q};
        end else if (i_addr == `QDC_MON_ADDR) begin
            rdata_d = {29'h0, code_of(mon_q)};
        end else if (i_addr == `QDC_STAT_ADDR) begin
            rdata_d = {30'h0, pol_q};
        end else if (gain_pg && aligned) begin
            rdata_d = {{24{gcal_q[ch_idx][7]}}, gcal_q[ch_idx]};
        end else if (zero_pg && aligned) begin
            rdata_d = {{23{zcal_q[ch_idx][8]}}, zcal_q[ch_idx]};
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= i_rd ? rdata_d : '0;
        end
    end
    assign o_rdata = rdata_q;

    // Polarity straps sampled each cycle
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pol_q <= 2'b00;
        end else begin
            pol_q <= {i_group_b_polarity_select, i_group_a_polarity_select};
        end
    end

    // gain bits set on either reset
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gain_q <= `QDC_GAIN_RST;
            mon_q  <= '{hiz: 1'b1, aux: 1'b0, chan: 4'h0};
        end else if (soft_rst) begin
            gain_q <= `QDC_GAIN_RST;
            mon_q  <= route_of(MON_OFF);
        end else begin
            if (wr_cmd) begin
                gain_q <= i_wdata[`QDC_CMD_GAIN_LSB +: 4];
            end
            if (wr_mon) begin
                mon_q <= route_of(i_wdata[2:0]);
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int n = 0; n < `QDC_CHANNELS; n++) begin
                gcal_q[n] <= `QDC_GCAL_RST;
                zcal_q[n] <= `QDC_ZCAL_RST;
            end
        end else if (soft_rst) begin
            for (int n = 0; n < `QDC_CHANNELS; n++) begin
                gcal_q[n] <= `QDC_GCAL_RST;
                zcal_q[n] <= `QDC_ZCAL_RST;
            end
        end else begin
            if (wr_gcal) begin
                gcal_q[ch_idx] <= i_wdata[7:0];
            end
            if (wr_zcal) begin
                zcal_q[ch_idx] <= i_wdata[8:0];
            end
        end
    end

    always_comb begin
        for (int n = 0; n < `QDC_CHANNELS; n++) begin
            o_chan_cfg[n].gain_x4   = gain_q[n];
            o_chan_cfg[n].unipolar  = pol_q[n/2];
            o_chan_cfg[n].twos_comp = !pol_q[n/2];
            // steps scaled in the analog path
            o_chan_cfg[n].gain_cal  = gcal_q[n];
            o_chan_cfg[n].zero_cal  = zcal_q[n];
        end
    end

    assign o_analog_monitor_output = mon_q;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_soft_rst;
        i_wr && i_addr == `QDC_CMD_ADDR && i_wdata[`QDC_CMD_SRST_BIT];
    endsequence

    sequence s_gain_wr;
        wr_cmd && !i_wdata[`QDC_CMD_SRST_BIT];
    endsequence

    property p_gain_reset;
        s_soft_rst |=> gain_q == 4'hf && o_chan_cfg[0].gain_cal == 8'h00;
    endproperty
    a_gain_reset: assert property (p_gain_reset)
        else $error("gain bits not set by soft reset");

    property p_gain_write;
        logic [3:0] v;
        (s_gain_wr, v = i_wdata[3:0]) |=> o_chan_cfg[3].gain_x4 == v[3]
            && o_chan_cfg[0].gain_x4 == v[0];
    endproperty
    a_gain_write: assert property (p_gain_write)
        else $error("gain bit does not follow write");

    property p_pol_b;
        i_reset_n |=>
            o_chan_cfg[2].unipolar == $past(i_group_b_polarity_select)
            && o_chan_cfg[3].unipolar == $past(i_group_b_polarity_select);
    endproperty
    a_pol_b: assert property (p_pol_b)
        else $error("group B polarity wrong");

    // Bipolar group A strap gives twos complement codes
    property p_format;
        i_reset_n |=> o_chan_cfg[1].twos_comp
            == !$past(i_group_a_polarity_select);
    endproperty
    a_format: assert property (p_format)
        else $error("code format disagrees with polarity");

    property p_mon;
        (i_wr && i_addr == `QDC_MON_ADDR && i_wdata[2:0] == 3'b101)
            |=> o_analog_monitor_output.aux && !o_analog_monitor_output.hiz
            && o_analog_monitor_output.chan == 4'h0;
    endproperty
    a_mon: assert property (p_mon)
        else $error("monitor not routed to aux");

    property p_groups;
        o_chan_cfg[0].unipolar == o_chan_cfg[1].unipolar
            && o_chan_cfg[2].unipolar == o_chan_cfg[3].unipolar;
    endproperty
    a_groups: assert property (p_groups)
        else $error("channels of one group differ");

    property p_gcal_wr;
        logic [7:0] v;
        (i_wr && i_addr == 8'h18 && !i_rd, v = i_wdata[7:0])
            |=> o_chan_cfg[2].gain_cal == v;
    endproperty
    a_gcal_wr: assert property (p_gcal_wr)
        else $error("gain calibration of channel 2 not stored");

    property p_gcal_rd;
        (i_rd && i_addr == 8'h10 && gcal_q[0] == 8'h80)
            |=> o_rdata == 32'hffffff80;
    endproperty
    a_gcal_rd: assert property (p_gcal_rd)
        else $error("gain calibration not sign extended");

    property p_zcal_wr;
        (i_wr && i_addr == 8'h20 && i_wdata[8:0] == 9'h100)
            |=> o_chan_cfg[0].zero_cal == 9'h100;
    endproperty
    a_zcal_wr: assert property (p_zcal_wr)
        else $error("zero calibration field width wrong");

    property p_stable;
        !i_wr |=> $stable(zcal_q[3]) && $stable(gain_q) && $stable(mon_q);
    endproperty
    a_stable: assert property (p_stable)
        else $error("setting changed without a write");

endmodule
`default_nettype wire

// File: quad_dac_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module quad_dac_host_model (
    // Clock
    input  wire logic        i_sys_clk,
    // Register port
    output logic      [7:0]  o_addr,
    output logic      [31:0] o_wdata,
    output logic             o_wr,
    output logic             o_rd,
    input  wire logic [31:0] i_rdata
);
    initial begin
        o_addr  = 8'h00;
        o_wdata = 32'h0;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end
    // requests launched just after an edge
    task automatic write(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_sys_clk);
        o_wr    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
        #1;
    endtask
    // Data taken in the cycle after the strobe
    task automatic read(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_sys_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_sys_clk);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
    endtask
endmodule
`default_nettype wire

// File: quad_dac_cfg_test.sv
`timescale 1ns/100ps
`default_nettype none
module quad_dac_cfg_test
    import quad_dac_cfg_pkg::*;
();
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, d;
    logic        wr, rd, pol_a = 1'b0, pol_b = 1'b0;
    chan_cfg_t   cfg [4];
    mon_route_t  mon;
    int          fails = 0, cmp_count = 0;
    logic [7:0]  gtab [4] = '{8'h80, 8'h7f, 8'hff, 8'h01};
    logic [8:0]  ztab [4] = '{9'h100, 9'h0ff, 9'h1ff, 9'h001};

    always #20 clk = ~clk;

    quad_dac_host_model u_host (.i_sys_clk(clk), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
    quad_dac_cfg u_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_group_a_polarity_select(pol_a),
        .i_group_b_polarity_select(pol_b),
        .o_chan_cfg(cfg), .o_analog_monitor_output(mon));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_ch(input int i, input logic g, input logic u,
                          input logic [7:0] gc, input logic [8:0] zc);
        chan_cfg_t e;
        e = {g, u, ~u, gc, zc};
        chk(32'(cfg[i]), 32'(e));
    endtask
    task automatic test_done;
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        for (int i = 0; i < 4; i++)
            chk_ch(i, 1'b1, 1'b0, 8'h00, 9'h000);
        chk(32'(mon), 32'h20);
        // Every strap pattern, ending with both low
        for (int p = 3; p >= 0; p--) begin
            @(posedge clk);
            pol_a <= p[0];
            pol_b <= p[1];
            @(posedge clk);
            #1;
            for (int i = 0; i < 4; i++)
                chk_ch(i, 1'b1, i < 2 ? p[0] : p[1], 8'h00, 9'h000);
            u_host.read(8'h08, d);
            chk(d, 32'(p));
        end
        for (int g = 5; g < 16; g += 5) begin
            u_host.write(8'h00, 32'(g));
            for (int i = 0; i < 4; i++)
                chk(32'(cfg[i].gain_x4), 32'((g >> i) & 1));
            u_host.read(8'h00, d);
            chk(d, 32'(g));
        end
        for (int i = 0; i < 4; i++) begin
            u_host.write(8'(8'h10 + 4 * i), 32'(signed'(gtab[i])));
            u_host.write(8'(8'h20 + 4 * i), 32'(signed'(ztab[i])));
        end
        for (int i = 0; i < 4; i++) begin
            chk_ch(i, 1'b1, 1'b0, gtab[i], ztab[i]);
            u_host.read(8'(8'h10 + 4 * i), d);
            chk(d, 32'(signed'(gtab[i])));
            u_host.read(8'(8'h20 + 4 * i), d);
            chk(d, 32'(signed'(ztab[i])));
        end
        for (int c = 0; c < 8; c++) begin
            u_host.write(8'h04, 32'(c));
            chk(32'(mon), c inside {[1:4]} ? 32'(1 << (c - 1)) :
                c == 5 ? 32'h10 : 32'h20);
            u_host.read(8'h04, d);
            // Codes 6 and 7 mean off and read back as 0
            chk(d, c < 6 ? 32'(c) : 32'h0);
        end
        u_host.write(8'h04, 32'h2);
        u_host.write(8'h00, 32'h10);
        for (int i = 0; i < 4; i++)
            chk_ch(i, 1'b1, 1'b0, 8'h00, 9'h000);
        chk(32'(mon), 32'h20);
        u_host.read(8'h00, d);
        chk(d, 32'h0f);
        @(posedge clk);
        #1;
        chk(rdata, 32'h0);
        // Unmapped and unaligned places
        u_host.write(8'h0c, 32'hffffffff);
        u_host.write(8'h11, 32'hffffffff);
        chk_ch(0, 1'b1, 1'b0, 8'h00, 9'h000);
        u_host.read(8'h0c, d);
        chk(d, 32'h0);
        u_host.read(8'h11, d);
        chk(d, 32'h0);
        u_host.write(8'h00, 32'h0);
        u_host.write(8'h14, 32'h7f);
        @(posedge clk);
        rst_n <= 1'b0;
        #1;
        chk_ch(1, 1'b1, 1'b0, 8'h00, 9'h000);
        test_done();
    end
endmodule
`default_nettype wire
